// *** dv/capacitive_proximity_processing_bench.sv ***
// Self-checking bench of the proximity core with a front-end model.
// Assumes a short scan tick; register reads are checked from a queue.
`timescale 1ns/10ps
module capacitive_proximity_processing_bench;
  import prx_pkg::*;
  logic sys_clk, sys_rst, reg_wr, reg_rd, pen_down, manual_op_mode;
  logic conv_cmd, chan_selected, touch_adc_busy, touch_go, near_flag;
  logic offset_cal_pending_flag, conversion_active_flag, host_irq_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] raw_val;
  logic rd_seen = 1'b0;
  prx_afe_req_type afe_req;
  prx_afe_rsp_type afe_rsp;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  int go_seen = 0;

  prx_core #(.TICK_CYCLES(20)) u_dut (.sys_clk, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pen_down, .manual_op_mode,
    .conv_cmd, .chan_selected, .touch_adc_busy, .touch_go, .afe_req,
    .afe_rsp, .near_flag, .offset_cal_pending_flag,
    .conversion_active_flag, .host_irq_n);
  prx_afe_model u_afe (.sys_clk, .sys_rst, .afe_req, .raw_val, .afe_rsp);

  // ------------------------------------------------------------
  // Bus tasks and comparisons
  // ------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic miss(input logic [31:0] got, input logic [31:0] e);
    check_count++;
    if (got !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, e);
    end
  endtask
  // Gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Flags are looked at mid-cycle, where every update has landed
  task automatic chk(ref logic got, input logic e);
    @(negedge sys_clk);
    miss({31'h0, got}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  task automatic scan(input logic [11:0] v);
    int n;
    raw_val <= v;
    for (n = 0; n < 400 && !conversion_active_flag; n++) @(posedge sys_clk);
    for (n = 0; n < 400 && conversion_active_flag; n++) @(posedge sys_clk);
  endtask
  // One manual convert pulse; without a select it then waits out the scan it starts
  task automatic conv(input logic [11:0] v, input logic sel);
    raw_val       <= v;
    chan_selected <= sel;
    conv_cmd      <= 1'b1;
    @(posedge sys_clk);
    conv_cmd      <= 1'b0;
    if (!sel)
      scan(v);
    else
      repeat (3) @(posedge sys_clk);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    if (rd_seen)
      miss(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    if (touch_go)
      go_seen <= go_seen + 1;
    cycles  <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {sys_rst, reg_wr, reg_rd, pen_down, manual_op_mode} = 5'h10;
    {conv_cmd, chan_selected, touch_adc_busy} = 3'h0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    raw_val   = 12'h5A5;
    void'($urandom(32'hD2658BD6));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rd(OFS_RAW, 32'h0);
    rd(OFS_STATUS, 32'h0);
    rd(8'h2C + 8'($urandom % 212), 32'h0);
    wr(OFS_COEF, 32'h0F0);
    wr(OFS_CTRL, 32'hB7);
    chk(offset_cal_pending_flag, 1'b1);
    scan(12'h100);
    chk(host_irq_n, 1'b0);
    rd(OFS_STATUS, 32'h40);
    chk(host_irq_n, 1'b1);
    rd(OFS_LOWPASS, 32'h100);
    scan(12'h300);
    rd(OFS_RAW, 32'h300);
    rd(OFS_LOWPASS, 32'h300);
    rd(OFS_BASE, 32'h120);
    rd(OFS_DELTA, 32'h1E0);
    rd(OFS_STATUS, 32'h09);
    scan(12'h300);
    rd(OFS_BASE, 32'h120);
    rd(OFS_STATUS, 32'h01);
    scan(12'h100);
    rd(OFS_BASE, 32'h120);
    chk(host_irq_n, 1'b0);
    rd(OFS_STATUS, 32'h10);
    scan(12'h100);
    rd(OFS_BASE, 32'h100);
    rd(OFS_DELTA, 32'h0);
    wr(OFS_CALCMD, 32'h1);
    chk(offset_cal_pending_flag, 1'b1);
    scan(12'h100);
    rd(OFS_STATUS, 32'h40);
    wr(OFS_CTRL, 32'h6F);
    scan(12'h100);
    rd(OFS_STATUS, 32'h20);
    pen_down <= 1'b1;
    raw_val  <= 12'h777;
    repeat (300) @(posedge sys_clk);
    rd(OFS_RAW, 32'h100);
    manual_op_mode <= 1'b1;
    conv(12'h180, 1'b0);
    repeat (2) @(posedge sys_clk);
    miss(go_seen, 32'h1);
    conv(12'h1C0, 1'b1);
    miss(go_seen, 32'h2);
    rd(OFS_RAW, 32'h180);
    wr(OFS_THRESH, 32'hFFF);
    wr(OFS_DRIFT, 32'h0010_0010);
    wr(OFS_TIMING, 32'h0000_0002);
    conv(12'h100, 1'b0);
    conv(12'h300, 1'b0);
    chk(offset_cal_pending_flag, 1'b0);
    conv(12'h300, 1'b0);
    chk(offset_cal_pending_flag, 1'b1);
    conv(12'h300, 1'b0);
    chk(offset_cal_pending_flag, 1'b0);
    wr(OFS_TIMING, 32'h0000_01FF);
    conv(12'h300, 1'b0);
    chk(offset_cal_pending_flag, 1'b1);
    repeat (2) @(posedge sys_clk);
    conclude();
  end
endmodule

// *** dv/prx_afe_model.sv ***
// Stand-in for the analog front end and the shared ADC of the core.
// Assumes the bench drives raw_val and seeds $urandom once.
`timescale 1ns/10ps
module prx_afe_model
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire prx_pkg::prx_afe_req_type afe_req,
  input  wire logic [11:0]              raw_val,
  output prx_pkg::prx_afe_rsp_type      afe_rsp
);
  import prx_pkg::*;
  int wait_cnt;

  // Done follows each start after 2 to 7 cycles; data scrambles outside
  // done so that a stale word is never taken for a fresh one
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wait_cnt <= 0;
      afe_rsp  <= '0;
    end
    else
    begin
      afe_rsp.done <= (wait_cnt == 1);
      afe_rsp.data <= (wait_cnt == 1) ? raw_val : ~afe_rsp.data;
      if (afe_req.start)
        wait_cnt <= 1 + int'($urandom % 6);
      else if (wait_cnt != 0)
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// *** src/prx_core.sv ***
// Proximity processing core: scan sequencer, filters, compensation
// requests, interrupt line and a plain register port.
// Assumes one 125 MHz clock, inputs synchronous to it, and an ADC front
// end that answers each start with one done pulse.
`timescale 1ns/10ps
module prx_core
#(
  parameter int TICK_CYCLES = prx_pkg::BASE_TICK_CYC
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  input  wire logic                     pen_down,
  input  wire logic                     manual_op_mode,
  input  wire logic                     conv_cmd,
  input  wire logic                     chan_selected,
  input  wire logic                     touch_adc_busy,
  output logic                          touch_go,
  output prx_pkg::prx_afe_req_type      afe_req,
  input  wire prx_pkg::prx_afe_rsp_type afe_rsp,
  output logic                          near_flag,
  output logic                          offset_cal_pending_flag,
  output logic                          conversion_active_flag,
  output logic                          host_irq_n
);
  import prx_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0]         ctrl, coef, thresh, drift, timing;
  prx_state_type       state;
  logic [SAMPLE_W-1:0] raw_cap_sample, lowpass_cap_sample, env_baseline;
  logic [SAMPLE_W-1:0] cal_ref;
  logic [DELTA_W-1:0]  user_delta;
  logic                seed, manual_run, scan_due;
  logic [31:0]         base_cnt;
  logic [2:0]          scan_cnt;
  logic [3:0]          up_cnt, dn_cnt;
  logic [7:0]          period_cnt, stuck_cnt;
  logic [3:0]          irq_flags;
  logic [2:0]          scan_interval_sel;
  logic                scan_on, scan_was_on, base_tick, scan_tick;
  logic                cal_request, host_cal, drift_req, periodic_req;
  logic                stuck_req, start_scan, start_manual, op_done;
  logic                cal_finish, near_rise, near_fall;
  logic [DELTA_W-1:0]  drift_val, next_delta;
  logic [3:0]          evt_set;
  logic                rd_status;

  assign scan_interval_sel = ctrl[CTRL_SCAN_LSB +: 3];
  assign scan_on           = (scan_interval_sel != 3'h0);

  // First-order recursive filter, out = (1-c)*x + c*prev, c = coef/16
  function automatic logic [SAMPLE_W-1:0] iir(
    input logic [SAMPLE_W-1:0] x,
    input logic [SAMPLE_W-1:0] prev,
    input logic [COEF_W-1:0]   c);
    logic [16:0] acc;
    acc = 17'((5'(COEF_ONE) - {1'b0, c}) * x) + 17'(c * prev);
    return acc[15:4];
  endfunction

  // ----------------------------------------------------------------
  // Scan period timebase: base tick, then scan tick
  // ----------------------------------------------------------------
  // Base unit divider; runs always so the scan grid stays regular
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      base_cnt <= 32'h0;
    else if (base_cnt == 32'(TICK_CYCLES - 1))
      base_cnt <= 32'h0;
    else
      base_cnt <= base_cnt + 32'h1;

  assign base_tick = (base_cnt == 32'(TICK_CYCLES - 1));
  assign scan_tick = base_tick && scan_on &&
                     (scan_cnt >= scan_interval_sel - 3'h1);

  // Scan divider counts base ticks up to the selected interval
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      scan_cnt <= 3'h0;
    else if (!scan_on || scan_tick)
      scan_cnt <= 3'h0;
    else if (base_tick)
      scan_cnt <= scan_cnt + 3'h1;

  // A tick seen while busy or pen down is dropped, not queued
  assign scan_due = scan_tick && (state == ST_IDLE);
  assign start_scan = scan_due && !manual_op_mode && !pen_down
                      && !touch_adc_busy;
  assign start_manual = manual_op_mode && conv_cmd && !chan_selected
                        && scan_on && (state == ST_IDLE);

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  // Configuration writes
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl   <= RST_CTRL;
      coef   <= RST_COEF;
      thresh <= RST_THRESH;
      drift  <= RST_DRIFT;
      timing <= RST_TIMING;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_CTRL:   ctrl   <= {24'h0, reg_wdata[7:0]};
        OFS_COEF:   coef   <= {20'h0, reg_wdata[11:0]};
        OFS_THRESH: thresh <= {19'h0, reg_wdata[12:0]};
        OFS_DRIFT:  drift  <= {4'h0, reg_wdata[27:16],
                               4'h0, reg_wdata[11:0]};
        OFS_TIMING: timing <= {8'h0, reg_wdata[23:0]};
        default:    ;
      endcase
    end

  assign host_cal  = reg_wr && (reg_addr == OFS_CALCMD)
                     && reg_wdata[CALCMD_GO];
  assign rd_status = reg_rd && (reg_addr == OFS_STATUS);

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:    reg_rdata <= ctrl;
        OFS_COEF:    reg_rdata <= coef;
        OFS_THRESH:  reg_rdata <= thresh;
        OFS_DRIFT:   reg_rdata <= drift;
        OFS_TIMING:  reg_rdata <= timing;
        OFS_STATUS:  reg_rdata <= {25'h0, irq_flags,
                                   conversion_active_flag,
                                   offset_cal_pending_flag, near_flag};
        OFS_RAW:     reg_rdata <= {20'h0, raw_cap_sample};
        OFS_LOWPASS: reg_rdata <= {20'h0, lowpass_cap_sample};
        OFS_BASE:    reg_rdata <= {20'h0, env_baseline};
        OFS_DELTA:   reg_rdata <= {19'h0, user_delta};
        default:     reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;

  // ----------------------------------------------------------------
  // Compensation request sources
  // ----------------------------------------------------------------
  // Enable edge of the scan setting
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      scan_was_on <= 1'b0;
    else
      scan_was_on <= scan_on;

  assign drift_val = DELTA_W'(env_baseline) - DELTA_W'(cal_ref);
  assign op_done   = (state == ST_STAT);
  // A zero count means inside the limits, so it can never request,
  // not even with a zero debounce setting
  assign drift_req = op_done && !seed &&
    ((up_cnt != 4'h0 && up_cnt >= timing[TIM_UPDEB_LSB +: 4]) ||
     (dn_cnt != 4'h0 && dn_cnt >= timing[TIM_DNDEB_LSB +: 4]));
  // At or past the rate, so lowering it never waits for a counter wrap
  assign periodic_req = op_done && (timing[TIM_PERIOD_LSB +: 8] != 8'h0)
    && (period_cnt >= timing[TIM_PERIOD_LSB +: 8] - 8'h1);
  assign stuck_req = op_done && near_flag &&
    (timing[TIM_STUCK_LSB +: 8] != 8'h0) &&
    (stuck_cnt == timing[TIM_STUCK_LSB +: 8] - 8'h1);
  assign cal_request = (scan_on && !scan_was_on) || host_cal
                       || drift_req || periodic_req || stuck_req;
  assign cal_finish  = (state == ST_CAL_WAIT) && afe_rsp.done;

  // Drift debounce: consecutive scans outside either limit
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      up_cnt <= 4'h0;
      dn_cnt <= 4'h0;
    end
    else if (cal_finish)
    begin
      up_cnt <= 4'h0;
      dn_cnt <= 4'h0;
    end
    else if (state == ST_DELTA)
    begin
      if (!drift_val[DELTA_W-1] &&
          drift_val > DELTA_W'(drift[DRIFT_UP_LSB +: 12]))
        up_cnt <= (up_cnt == 4'hF) ? up_cnt : up_cnt + 4'h1;
      else
        up_cnt <= 4'h0;
      if (drift_val[DELTA_W-1] &&
          (DELTA_W'(0) - drift_val) > DELTA_W'(drift[DRIFT_DN_LSB +: 12]))
        dn_cnt <= (dn_cnt == 4'hF) ? dn_cnt : dn_cnt + 4'h1;
      else
        dn_cnt <= 4'h0;
    end

  // Periodic and stuck counters, both counted in completed scans
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      period_cnt <= 8'h0;
      stuck_cnt  <= 8'h0;
    end
    else if (op_done)
    begin
      period_cnt <= periodic_req ? 8'h0 : period_cnt + 8'h1;
      stuck_cnt  <= (near_flag && !stuck_req) ? stuck_cnt + 8'h1 : 8'h0;
    end

  // Pending flag: a new request in the finishing cycle keeps it set
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      offset_cal_pending_flag <= 1'b0;
    else if (cal_request)
      offset_cal_pending_flag <= 1'b1;
    else if (cal_finish)
      offset_cal_pending_flag <= 1'b0;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  // Compensation only branches off the idle-to-raw step
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (start_scan || start_manual)
            state <= offset_cal_pending_flag ? ST_CAL : ST_RAW;
        ST_CAL:      state <= ST_CAL_WAIT;
        ST_CAL_WAIT: if (afe_rsp.done) state <= ST_RAW;
        ST_RAW:      state <= ST_RAW_WAIT;
        ST_RAW_WAIT: if (afe_rsp.done) state <= ST_FILT;
        ST_FILT:     state <= ST_BASE;
        ST_BASE:     state <= ST_DELTA;
        ST_DELTA:    state <= ST_STAT;
        ST_STAT:     state <= ST_IDLE;
        default:     state <= ST_IDLE;
      endcase
    end

  // ADC starts and ownership; touch_go follows a manual scan, or comes at once for a conv_cmd in manual mode that starts none
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      afe_req    <= '0;
      manual_run <= 1'b0;
      touch_go   <= 1'b0;
    end
    else
    begin
      afe_req.start <= (state == ST_CAL) || (state == ST_RAW);
      afe_req.cal   <= (state == ST_CAL) ||
                       (afe_req.cal && state == ST_CAL_WAIT);
      if (start_manual)
        manual_run <= 1'b1;
      else if (op_done)
        manual_run <= 1'b0;
      touch_go <= (op_done && manual_run) ||
        (manual_op_mode && conv_cmd && !start_manual);
    end

  // Conversion flag covers the whole scan
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      conversion_active_flag <= 1'b0;
    else
      conversion_active_flag <= (start_scan || start_manual) ||
        (conversion_active_flag && !op_done);

  // ----------------------------------------------------------------
  // Data path: raw, lowpass, baseline, delta, near flag
  // ----------------------------------------------------------------
  assign next_delta = DELTA_W'(lowpass_cap_sample)
                      - DELTA_W'(env_baseline);

  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
    begin
      raw_cap_sample     <= '0;
      lowpass_cap_sample <= '0;
      env_baseline       <= '0;
      cal_ref            <= '0;
      user_delta         <= '0;
      near_flag          <= 1'b0;
      seed               <= 1'b1;
    end
    else
    begin
      case (state)
        ST_CAL_WAIT:
          if (afe_rsp.done)
            seed <= 1'b1;                  // Filters restart after cal
        ST_RAW_WAIT:
          if (afe_rsp.done)
            raw_cap_sample <= afe_rsp.data;
        ST_FILT:
          lowpass_cap_sample <= seed ? raw_cap_sample :
            iir(raw_cap_sample, lowpass_cap_sample,
                coef[COEF_RAW_LSB +: COEF_W]);
        ST_BASE:
          if (seed)
          begin
            env_baseline <= lowpass_cap_sample;
            cal_ref      <= lowpass_cap_sample;
          end
          else if (!near_flag)
            env_baseline <= iir(lowpass_cap_sample, env_baseline,
              (lowpass_cap_sample >= env_baseline) ?
                coef[COEF_UP_LSB +: COEF_W] :
                coef[COEF_DN_LSB +: COEF_W]);
        ST_DELTA:
          user_delta <= next_delta;
        ST_STAT:
        begin
          near_flag <= ($signed(user_delta) >=
                        $signed(thresh[DELTA_W-1:0]));
          seed      <= 1'b0;
        end
        default: ;
      endcase
    end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  assign near_rise = (state == ST_STAT) && !near_flag &&
                     ($signed(user_delta) >= $signed(thresh[DELTA_W-1:0]));
  assign near_fall = (state == ST_STAT) && near_flag &&
                     ($signed(user_delta) < $signed(thresh[DELTA_W-1:0]));
  assign evt_set = {
    cal_finish && ctrl[CTRL_CAL_EN],
    op_done && ctrl[CTRL_IRQSEL] && ctrl[CTRL_DONE_EN],
    near_fall && !ctrl[CTRL_IRQSEL] && ctrl[CTRL_FAR_EN],
    near_rise && ctrl[CTRL_NEAR_EN]};

  // Sticky events; a status read clears them, but a new event wins
  always_ff @(posedge sys_clk or posedge sys_rst)
    if (sys_rst)
      irq_flags <= 4'h0;
    else
      irq_flags <= evt_set | (rd_status ? 4'h0 : irq_flags);

  assign host_irq_n = ~|irq_flags;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  chk_pend_holds: assert property (
    offset_cal_pending_flag && !cal_finish |=> offset_cal_pending_flag)
    else $error("pending flag dropped before compensation end");
  chk_host_request: assert property (
    host_cal |=> offset_cal_pending_flag)
    else $error("host compensation request lost");
  chk_enable_request: assert property (
    scan_on && !scan_was_on |=> offset_cal_pending_flag)
    else $error("enabling scans did not request compensation");
  chk_cal_at_start: assert property (
    state == ST_CAL |-> $past(state) == ST_IDLE)
    else $error("compensation started mid scan");
  chk_conv_held: assert property (
    (state != ST_IDLE) |-> conversion_active_flag)
    else $error("conversion flag low during scan");
  chk_base_frozen: assert property (
    state == ST_BASE && near_flag && !seed |=> $stable(env_baseline))
    else $error("baseline moved while near");
  chk_scan_off: assert property (
    state == ST_IDLE && !scan_on |=> state == ST_IDLE)
    else $error("scan ran with zero scan setting");
  chk_pen_skip: assert property (
    state == ST_IDLE && !manual_op_mode && pen_down |=> state == ST_IDLE)
    else $error("scan ran while pen down");
  chk_near_compare: assert property (
    state == ST_STAT |=> near_flag == ($signed($past(user_delta)) >=
      $signed($past(thresh[DELTA_W-1:0]))))
    else $error("near flag disagrees with threshold");
  chk_delta_value: assert property (
    state == ST_DELTA |=> user_delta ==
      DELTA_W'($past(lowpass_cap_sample)) - DELTA_W'($past(env_baseline)))
    else $error("delta not lowpass minus baseline");
  chk_scan_length: assert property (
    state == ST_FILT |-> ##4 state == ST_IDLE)
    else $error("processing steps out of order");

endmodule

// *** src/prx_pkg.sv ***
// Constants, types and register map of the proximity processing core.
// Assumes a 125 MHz system clock and a 12-bit proximity ADC result.
package prx_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int BASE_TICK_US = 1000;  // Scan-period base unit in us
  localparam int BASE_TICK_CYC = BASE_TICK_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int DELTA_W  = 13;
  localparam int COEF_W   = 4;
  localparam int COEF_ONE = 16;        // Coefficient full scale

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CALCMD  = 8'h04;
  localparam logic [7:0] OFS_COEF    = 8'h08;
  localparam logic [7:0] OFS_THRESH  = 8'h0C;
  localparam logic [7:0] OFS_DRIFT   = 8'h10;
  localparam logic [7:0] OFS_TIMING  = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_RAW     = 8'h1C;
  localparam logic [7:0] OFS_LOWPASS = 8'h20;
  localparam logic [7:0] OFS_BASE    = 8'h24;
  localparam logic [7:0] OFS_DELTA   = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SCAN_LSB   = 0;   // scan_interval_sel [2:0]
  localparam int CTRL_IRQSEL     = 3;
  localparam int CTRL_NEAR_EN    = 4;
  localparam int CTRL_FAR_EN     = 5;
  localparam int CTRL_DONE_EN    = 6;
  localparam int CTRL_CAL_EN     = 7;
  localparam int CALCMD_GO       = 0;
  localparam int COEF_RAW_LSB    = 0;
  localparam int COEF_UP_LSB     = 4;
  localparam int COEF_DN_LSB     = 8;
  localparam int DRIFT_UP_LSB    = 0;
  localparam int DRIFT_DN_LSB    = 16;
  localparam int TIM_UPDEB_LSB   = 0;
  localparam int TIM_DNDEB_LSB   = 4;
  localparam int TIM_PERIOD_LSB  = 8;
  localparam int TIM_STUCK_LSB   = 16;
  localparam int ST_NEAR         = 0;
  localparam int ST_PEND         = 1;
  localparam int ST_CONV         = 2;
  localparam int ST_EVT_LSB      = 3;   // Four sticky event bits

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_COEF   = 32'h0000_0248;
  localparam logic [31:0] RST_THRESH = 32'h0000_0040;
  localparam logic [31:0] RST_DRIFT  = 32'h0100_0100;
  localparam logic [31:0] RST_TIMING = 32'h0000_0033;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the scan path except ST_STAT to ST_IDLE
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_CAL      = 4'h1,
    ST_CAL_WAIT = 4'h3,
    ST_RAW      = 4'h2,
    ST_RAW_WAIT = 4'h6,
    ST_FILT     = 4'h7,
    ST_BASE     = 4'h5,
    ST_DELTA    = 4'h4,
    ST_STAT     = 4'hC
  } prx_state_type;

  // ----------------------------------------------------------------
  // Carriers towards and from the shared ADC front end
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;                      // One-cycle start pulse
    logic cal;                        // Run offset compensation
  } prx_afe_req_type;

  typedef struct packed {
    logic                done;        // One-cycle completion pulse
    logic [SAMPLE_W-1:0] data;        // Unsigned raw result
  } prx_afe_rsp_type;

endpackage
